// File: logic/imr_consts.svh
// Constants for the two-wire master receive sequencer
// Assumes inclusion by bare name from logic files
`ifndef IMR_CONSTS_SVH
`define IMR_CONSTS_SVH
`define IMR_BITS_PER_BYTE  4'h8
`define IMR_ACK_BIT_INDEX  4'h9
`define IMR_BRG_RELOAD_RST 8'h04
`define IMR_BYTE_RST       8'h00
`endif

// File: logic/imr_pkg.sv
// Types for the two-wire master receive sequencer
// Assumes imr_consts.svh is on the include path
package imr_pkg;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b00_0001,
      ST_START = 6'b00_0010,
      ST_ADDR  = 6'b00_0100,
      ST_RECV  = 6'b00_1000,
      ST_ACK   = 6'b01_0000,
      ST_HOLD  = 6'b10_0000
   } imr_state_t;

   typedef struct packed {
      logic receiveEnable;
      logic startEnable;
      logic ackSequenceEnable;
      logic ackDataValue;
   } imr_ctrl_t;

   typedef struct packed {
      logic bufferFullFlag;
      logic receiveOverflowFlag;
      logic writeCollisionFlag;
      logic ackStatus;
      logic serialIrqFlag;
   } imr_status_t;
endpackage : imr_pkg

// File: logic/imr_brg.sv
// Baud rate generator: pulses on each rollover while running
// Assumes same clock as the sequencer
`timescale 1ns/1ps
`default_nettype none
module imr_brg #(
   parameter int RW = 8
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // Control
   input  wire logic          run,
   input  wire logic [RW-1:0] reload,
   // Rollover
   output logic               rollover
);
   logic [RW-1:0] count;

   if (RW < 2) begin : g_rw_check
      $error("imr_brg: RW too small");
   end

   always_ff @(posedge mclk) begin
      if (rst || !run) begin
         count    <= '0;
         rollover <= 1'b0;
      end else if (count == '0) begin
         count    <= reload;
         rollover <= 1'b1;
      end else begin
         count    <= count - 1'b1;
         rollover <= 1'b0;
      end
   end
endmodule : imr_brg
`default_nettype wire

// File: logic/imr_sequencer.sv
// Master receive sequencer of a two-wire serial port
// Assumes CPU strobes are one-cycle pulses on mclk; bus pins are open drain
//
// Notes on behaviour
// - Receive-enable set ignored unless module idle or holding
// - In receive, each rollover toggles SCL; every second one, ending the high phase, samples SDA
// - After eighth fall: load buffer, flag, hold SCL
// - After byte, stay in hold and accept next command
// - Buffer-full set on load, cleared by read
// - Overflow when byte completes with buffer full
// - Buffer write during shifting sets collision
// - Start-enable makes Start, then interrupt flag
// - Address write shifts eight bits out immediately
// - Ninth clock samples slave ack, flags interrupt
// - Ack-enable clocks ack data out, flags interrupt
// - Rate generator paces every bus operation
`include "imr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module imr_sequencer #(
   parameter int BRG_W = 8
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // CPU control strobes
   input  wire logic              setReceiveEnable,
   input  wire logic              setStartEnable,
   input  wire logic              setAckSequenceEnable,
   input  wire logic              ackDataIn,
   input  wire logic              clearIrq,
   input  wire logic              clearOverflow,
   input  wire logic              clearCollision,
   input  wire logic [BRG_W-1:0]  brgReload,
   // CPU buffer access
   input  wire logic              bufWrite,
   input  wire logic [7:0]        bufWriteData,
   input  wire logic              bufRead,
   output logic [7:0]             serialDataBuffer,
   // Control and status view
   output imr_pkg::imr_ctrl_t     serialControlTwo,
   output imr_pkg::imr_status_t   status,
   // Bus pins
   input  wire logic              sclIn,
   output logic                   sclOut,
   output logic                   sclOe,
   input  wire logic              sdaIn,
   output logic                   sdaOut,
   output logic                   sdaOe
);
   imr_pkg::imr_state_t state;
   logic       sclMeta, sclSync, sdaMeta, sdaSync;
   logic       rollover, brgRun, sclLevel, sdaLow;
   logic [3:0] bitCount;
   logic [7:0] rxShiftRegister, txShift;
   logic       phase;

   if (BRG_W < 2) begin : g_brg_w_check
      $error("imr_sequencer: BRG_W too small");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge mclk) begin
      if (rst) begin
         sclMeta <= 1'b1;
         sclSync <= 1'b1;
         sdaMeta <= 1'b1;
         sdaSync <= 1'b1;
      end else begin
         sclMeta <= sclIn;
         sclSync <= sclMeta;
         sdaMeta <= sdaIn;
         sdaSync <= sdaMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Rate generator runs in every active state
   assign brgRun = (state != imr_pkg::ST_IDLE) && (state != imr_pkg::ST_HOLD);

   imr_brg #(.RW(BRG_W)) u_brg (
      .mclk     (mclk),
      .rst      (rst),
      .run      (brgRun),
      .reload   (brgReload),
      .rollover (rollover)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge mclk) begin
      if (rst) begin
         state           <= imr_pkg::ST_IDLE;
         sclLevel        <= 1'b1;
         sdaLow          <= 1'b0;
         bitCount        <= 4'h0;
         phase           <= 1'b0;
         rxShiftRegister <= `IMR_BYTE_RST;
         txShift         <= `IMR_BYTE_RST;
         serialControlTwo <= '0;
      end else begin
         unique case (state)
            imr_pkg::ST_IDLE, imr_pkg::ST_HOLD: begin
               if (setStartEnable) begin
                  serialControlTwo.startEnable <= 1'b1;
                  state    <= imr_pkg::ST_START;
                  phase    <= 1'b0;
               end else if (setReceiveEnable) begin
                  serialControlTwo.receiveEnable <= 1'b1;
                  state    <= imr_pkg::ST_RECV;
                  bitCount <= 4'h0;
                  sdaLow   <= 1'b0;
               end else if (setAckSequenceEnable) begin
                  serialControlTwo.ackSequenceEnable <= 1'b1;
                  serialControlTwo.ackDataValue      <= ackDataIn;
                  sdaLow   <= ~ackDataIn;
                  state    <= imr_pkg::ST_ACK;
                  phase    <= 1'b0;
               end else if (bufWrite) begin
                  txShift  <= bufWriteData;
                  sdaLow   <= ~bufWriteData[7];
                  bitCount <= 4'h0;
                  state    <= imr_pkg::ST_ADDR;
               end
            end
            imr_pkg::ST_START: begin
               if (rollover) begin
                  if (!phase) begin
                     sdaLow <= 1'b1;
                     phase  <= 1'b1;
                  end else begin
                     sclLevel <= 1'b0;
                     serialControlTwo.startEnable <= 1'b0;
                     state    <= imr_pkg::ST_HOLD;
                  end
               end
            end
            imr_pkg::ST_ADDR: begin
               if (rollover) begin
                  sclLevel <= ~sclLevel;
                  if (!sclLevel && sclSync == 1'b0) begin
                     if (bitCount == `IMR_BITS_PER_BYTE) begin
                        sdaLow <= 1'b0;
                     end
                  end else if (sclLevel) begin
                     bitCount <= bitCount + 4'h1;
                     if (bitCount < `IMR_BITS_PER_BYTE - 4'h1) begin
                        txShift <= {txShift[6:0], 1'b0};
                        sdaLow  <= ~txShift[6];
                     end else begin
                        sdaLow <= 1'b0;
                     end
                     if (bitCount == `IMR_BITS_PER_BYTE) begin
                        serialControlTwo.receiveEnable <= 1'b0;
                        state <= imr_pkg::ST_HOLD;
                     end
                  end
               end
            end
            imr_pkg::ST_RECV: begin
               if (rollover) begin
                  sclLevel <= ~sclLevel;
                  if (sclLevel) begin
                     // Sample at the end of the high phase, once the pin has settled
                     rxShiftRegister <= {rxShiftRegister[6:0], sdaSync};
                     bitCount <= bitCount + 4'h1;
                     if (bitCount == `IMR_BITS_PER_BYTE - 4'h1) begin
                        serialControlTwo.receiveEnable <= 1'b0;
                        state <= imr_pkg::ST_HOLD;
                     end
                  end
               end
            end
            imr_pkg::ST_ACK: begin
               if (rollover) begin
                  sclLevel <= ~sclLevel;
                  if (sclLevel) begin
                     sdaLow <= 1'b0;
                     serialControlTwo.ackSequenceEnable <= 1'b0;
                     state  <= imr_pkg::ST_HOLD;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Completion event one cycle ahead of the flags
   logic byteDone, addrAckDone, startDone, ackDone;
   assign byteDone    = (state == imr_pkg::ST_RECV) && rollover && sclLevel
                        && (bitCount == `IMR_BITS_PER_BYTE - 4'h1);
   assign addrAckDone = (state == imr_pkg::ST_ADDR) && rollover && sclLevel
                        && (bitCount == `IMR_BITS_PER_BYTE);
   assign startDone   = (state == imr_pkg::ST_START) && rollover && phase;
   assign ackDone     = (state == imr_pkg::ST_ACK) && rollover && sclLevel;

   ////////////////////////////////////////////////////////////////////////
   // Receive buffer; writes land only when the bus is quiet
   always_ff @(posedge mclk) begin
      if (rst) begin
         serialDataBuffer <= `IMR_BYTE_RST;
      end else if (byteDone) begin
         serialDataBuffer <= {rxShiftRegister[6:0], sdaSync};
      end else if (bufWrite && (state == imr_pkg::ST_IDLE || state == imr_pkg::ST_HOLD)
                   && !setStartEnable && !setReceiveEnable && !setAckSequenceEnable) begin
         serialDataBuffer <= bufWriteData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overflow, collision, ack status, interrupt flag
   always_ff @(posedge mclk) begin
      if (rst) begin
         status.bufferFullFlag      <= 1'b0;
         status.receiveOverflowFlag <= 1'b0;
         status.writeCollisionFlag  <= 1'b0;
         status.ackStatus           <= 1'b1;
         status.serialIrqFlag       <= 1'b0;
      end else begin
         if (byteDone) begin
            status.bufferFullFlag <= 1'b1;
         end else if (bufRead) begin
            status.bufferFullFlag <= 1'b0;
         end
         if (byteDone && status.bufferFullFlag) begin
            status.receiveOverflowFlag <= 1'b1;
         end else if (clearOverflow) begin
            status.receiveOverflowFlag <= 1'b0;
         end
         if (bufWrite && brgRun) begin
            status.writeCollisionFlag <= 1'b1;
         end else if (clearCollision) begin
            status.writeCollisionFlag <= 1'b0;
         end
         if (addrAckDone) begin
            status.ackStatus <= sdaSync;
         end
         if (byteDone || addrAckDone || startDone || ackDone) begin
            status.serialIrqFlag <= 1'b1;
         end else if (clearIrq) begin
            status.serialIrqFlag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Open-drain pin drivers, registered
   always_ff @(posedge mclk) begin
      if (rst) begin
         sclOut <= 1'b0;
         sclOe  <= 1'b0;
         sdaOut <= 1'b0;
         sdaOe  <= 1'b0;
      end else begin
         sclOut <= 1'b0;
         sclOe  <= ~sclLevel;
         sdaOut <= 1'b0;
         sdaOe  <= sdaLow && (state != imr_pkg::ST_RECV);
      end
   end
endmodule : imr_sequencer
`default_nettype wire

// File: tb/imr_sequencer_sva.sv
// Assertions for the receive sequencer
// Assumes binding onto imr_sequencer, one clock
`timescale 1ns/1ps
`default_nettype none
module imr_seq_chk (
   // Clock and reset
   input wire logic                mclk,
   input wire logic                rst,
   // Strobes and views
   input wire logic                setReceiveEnable,
   input wire logic                bufWrite,
   input wire logic                bufRead,
   input wire imr_pkg::imr_ctrl_t  serialControlTwo,
   input wire imr_pkg::imr_status_t status,
   input wire logic                sclOe,
   input wire logic                sdaOe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   wire logic rcv = serialControlTwo.receiveEnable;
   wire logic ack = serialControlTwo.ackSequenceEnable;
   ////////////////////////////////////////////////////////////////
   rst_vals_a: assert property (disable iff (1'b0) rst |=>
      status == 5'h02 && !sclOe && !sdaOe) else $error("reset values wrong");
   rcv_done_a: assert property ($fell(rcv) |-> ##[0:1]
      (status.bufferFullFlag && status.serialIrqFlag)) else $error("byte end flags");
   rcv_hold_a: assert property ($fell(rcv) |-> ##[0:1] sclOe) else $error("scl not held");
   rcv_ign_a: assert property (setReceiveEnable &&
      (serialControlTwo.startEnable || ack) |=> !rcv) else $error("receive not ignored");
   coll_set_a: assert property (bufWrite && rcv |=> status.writeCollisionFlag)
      else $error("no collision");
   ovf_set_a: assert property ($fell(rcv) && $past(status.bufferFullFlag) && !$past(bufRead)
      |-> ##[0:1] status.receiveOverflowFlag) else $error("no overflow");
   ack_end_a: assert property ($rose(ack) |-> ##[1:600] !ack) else $error("ack stuck");
   ack_irq_a: assert property ($fell(ack) |-> ##[0:1] status.serialIrqFlag)
      else $error("no ack irq");
   start_irq_a: assert property ($fell(serialControlTwo.startEnable) |-> ##[0:1]
      status.serialIrqFlag) else $error("no start irq");
   cover property ($fell(rcv));
   cover property ($fell(ack));
   cover property (status.receiveOverflowFlag);
endmodule : imr_seq_chk
bind imr_sequencer imr_seq_chk u_chk (.mclk(mclk), .rst(rst), .setReceiveEnable(setReceiveEnable),
   .bufWrite(bufWrite), .bufRead(bufRead), .serialControlTwo(serialControlTwo), .status(status),
   .sclOe(sclOe), .sdaOe(sdaOe));
`default_nettype wire

// File: tb/imr_slave_model.sv
// Addressed slave on the two-wire bus, open drain with pull-ups
// Assumes it sees the master's pin enables each mclk
`timescale 1ns/1ps
`default_nettype none
module imr_slave_model (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // Bus pins
   input wire logic        sclOe,
   input wire logic        sdaOe,
   output logic            sclIn,
   output logic            sdaIn,
   // Data
   input wire logic [7:0]  txByte,
   output logic [7:0]      rxAddr
);
   logic       sclQ;
   logic       sdaQ;
   logic       readPh;
   logic [3:0] bitCnt;
   logic       sdaDrv;
   // Released lines float to the pull-up level
   assign sclIn  = !sclOe;
   assign sdaDrv = readPh ? (bitCnt < 4'h8 && !txByte[3'(4'h7 - bitCnt)]) : (bitCnt == 4'h8);
   assign sdaIn  = !(sdaOe || sdaDrv);
   always_ff @(posedge mclk) begin
      sclQ <= sclIn;
      sdaQ <= sdaIn;
      if (rst) begin
         bitCnt <= 4'h0;
         readPh <= 1'b0;
      end else if (sclQ && sclIn && sdaQ && !sdaIn) begin
         bitCnt <= 4'hF;
         readPh <= 1'b0;
      end else if (sclQ && !sclIn) begin
         bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
         if (bitCnt == 4'h8) readPh <= 1'b1;
      end else if (!sclQ && sclIn && !readPh && bitCnt < 4'h8) begin
         rxAddr <= {rxAddr[6:0], sdaIn};
      end
   end
endmodule : imr_slave_model
`default_nettype wire

// File: tb/tb_imr_sequencer.sv
// Testbench for the two-wire master receive sequencer
// Assumes the slave model on the far side, mclk at 10 MHz
`timescale 1ns/1ps
`default_nettype none
module tb_imr_sequencer;
   localparam logic [7:0] RCV = 8'h01, STA = 8'h02, ACK = 8'h04, CLI = 8'h08;
   localparam logic [7:0] RD = 8'h10, WR = 8'h20, CLO = 8'h40, CLC = 8'h80;
   logic                 mclk, rst, ackD, sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe;
   logic [7:0]           cmd, wrData, txByte, rxAddr, rdBuf;
   imr_pkg::imr_ctrl_t   ctl;
   imr_pkg::imr_status_t st;
   int                   mismatches, cmp_count;
   imr_sequencer dut (.mclk(mclk), .rst(rst), .setReceiveEnable(cmd[0]), .setStartEnable(cmd[1]),
      .setAckSequenceEnable(cmd[2]), .ackDataIn(ackD), .clearIrq(cmd[3]), .clearOverflow(cmd[6]),
      .clearCollision(cmd[7]), .brgReload(8'h02), .bufWrite(cmd[5]), .bufWriteData(wrData),
      .bufRead(cmd[4]), .serialDataBuffer(rdBuf), .serialControlTwo(ctl), .status(st),
      .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
   imr_slave_model slave (.mclk(mclk), .rst(rst), .sclOe(sclOe), .sdaOe(sdaOe), .sclIn(sclIn),
      .sdaIn(sdaIn), .txByte(txByte), .rxAddr(rxAddr));
   ////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic pulse(input logic [7:0] m);
      @(posedge mclk) cmd <= m;
      @(posedge mclk) cmd <= 8'h00;
      #1;
   endtask : pulse
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : chk
   task automatic waitIrq();
      int n;
      n = 0;
      while (st.serialIrqFlag !== 1'b1 && n < 2000) begin
         @(posedge mclk) #1;
         n++;
      end
      chk({7'h00, st.serialIrqFlag}, 8'h01, "irq missing");
      pulse(CLI);
   endtask : waitIrq
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1; cmd = 8'h00; wrData = 8'h00; ackD = 1'b0; txByte = 8'hA5;
      mismatches = 0; cmp_count = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk) #1;
      chk({3'h0, st}, 8'h02, "reset flags");
      pulse(STA);
      pulse(RCV);
      chk({7'h00, ctl.receiveEnable}, 8'h00, "receive not ignored");
      waitIrq();
      @(posedge mclk) wrData <= 8'h53;
      pulse(WR);
      waitIrq();
      chk(rxAddr, 8'h53, "address on wire");
      chk({7'h00, st.ackStatus}, 8'h00, "slave ack");
      $display("test address done");
      for (int i = 0; i < 2; i++) begin
         txByte = i ? 8'h3C : 8'hA5;
         @(posedge mclk) wrData <= 8'hC3;
         pulse(RCV);
         pulse(WR);
         chk({7'h00, st.writeCollisionFlag}, 8'h01, "collision");
         chk(rdBuf, i ? 8'hA5 : 8'h53, "buffer kept on collision");
         pulse(CLC);
         waitIrq();
         chk(rdBuf, txByte, "received byte");
         chk({7'h00, sclOe}, 8'h01, "scl held low");
         chk({7'h00, st.bufferFullFlag}, 8'h01, "buffer full");
         chk({7'h00, st.receiveOverflowFlag}, 8'(i), "overflow");
         chk({7'h00, ctl.receiveEnable}, 8'h00, "receive cleared");
         @(posedge mclk) ackD <= i[0];
         pulse(ACK);
         waitIrq();
         chk({7'h00, ctl.ackSequenceEnable}, 8'h00, "ack cleared");
         chk({7'h00, ctl.ackDataValue}, {7'h00, ackD}, "ack value kept");
         $display("test byte %0d done", i);
      end
      pulse(RD);
      chk({7'h00, st.bufferFullFlag}, 8'h00, "buffer full after read");
      pulse(CLO);
      chk({7'h00, st.receiveOverflowFlag}, 8'h00, "overflow clear");
      chk({6'h00, sclOut, sdaOut}, 8'h00, "pins only pull low");
      $display("test read done");
      summarize();
   end
endmodule : tb_imr_sequencer
`default_nettype wire
